// ===== logic/tmc16_core.sv
// Top of the 16-bit timer core with byte-wide CPU access through a shared latch
// Summary of operation
// - Power-off bit set keeps timer disabled
// - No clock source selected holds counter
// - Tick from prescaler or external pin edge
// - Compares run on each tick, match sets flag
// - Compare writes go through a buffer
// - Filtered capture edge copies counter unless capture is TOP
// - TOP fixed 0xFF/0x1FF/0x3FF, compare A, capture
// - Compare A as TOP gives no PWM
// - BOTTOM is zero, MAX is all ones
// - One shared high-byte latch per timer
// - High write to latch, low write commits
// - Low read copies high byte to latch
// - Compare reads bypass the latch
// - Four flags, each with its mask bit
// - Capture flag set with capture, one clears
// - CPU counter write beats clear and count
module tmc16_core
	import tmc16_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic timer_power_off_bit,
	input wire logic [2:0] clock_select,
	input wire logic [2:0] top_select,
	input wire logic pwm_mode,
	input wire logic count_down,
	input wire logic filter_enable,
	input wire logic capture_rising,
	input wire logic [2:0] bus_addr,
	input wire logic bus_write,
	input wire logic bus_read,
	input wire logic [7:0] bus_wdata,
	input wire logic flag_write,
	input wire logic [3:0] flag_wdata,
	input wire logic mask_write,
	input wire logic [3:0] mask_wdata,
	input wire logic capture_input_pin,
	input wire logic external_count_pin,
	output logic [7:0] bus_rdata,
	output logic [3:0] interrupt_flag_register,
	output logic [3:0] interrupt_mask_register,
	output logic interrupt_request,
	output logic [15:0] counter_value,
	output logic compare_match_a,
	output logic compare_match_b,
	output logic pwm_output_a_allowed,
	output logic at_bottom,
	output logic at_max,
	output logic at_top,
	output logic timer_tick
);

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	tmc16_edge_if edges ();

	tmc16_edge_detect u_edge (
		.clock(clock),
		.rst(rst),
		.capture_input_pin(capture_input_pin),
		.external_count_pin(external_count_pin),
		.filter_enable(filter_enable),
		.capture_rising(capture_rising),
		.count_rising(clock_select == TMC16_CS_EXT_RISE),
		.edges(edges)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [TMC16_PRESC_WIDTH-1:0] presc; // Prescaler count
		logic [15:0] cnt; // Counter
		logic [15:0] cmpa_buf; // Compare A buffer
		logic [15:0] cmpb_buf; // Compare B buffer
		logic [15:0] cmpa; // Active compare A
		logic [15:0] cmpb; // Active compare B
		logic [15:0] cap; // Capture value
		logic [7:0] latch; // Shared high-byte latch
		logic [3:0] flags; // Sticky event flags
		logic [3:0] mask; // Interrupt mask
		logic [7:0] rdata; // Read data
		logic irq; // Interrupt request
		logic tick; // Tick that counted this cycle, not a CPU counter write
		logic mat_a; // Match A pulse
		logic mat_b; // Match B pulse
		logic bot; // At BOTTOM
		logic mx; // At MAX
		logic tp; // At TOP
		logic pwm_a; // Compare A free for PWM
	} tmc16_state_type;

	tmc16_state_type s_q, s_d;

	// Prescaler tap selection; the prescaler runs free, so the first tick after a select change may come early
	function automatic logic presc_tap(input logic [2:0] cs, input logic [TMC16_PRESC_WIDTH-1:0] p);
		logic r;
		r = 1'b0;
		case (cs)
			TMC16_CS_DIV1: r = 1'b1;
			TMC16_CS_DIV8: r = &p[2:0];
			TMC16_CS_DIV64: r = &p[5:0];
			TMC16_CS_DIV256: r = &p[7:0];
			TMC16_CS_DIV1024: r = &p[9:0];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Next state of the whole core
	always_comb begin
		logic tick;
		logic [15:0] top;
		logic [15:0] next_cnt;
		logic [3:0] set_ev;
		logic cnt_written;
		logic buf_update;
		tick = 1'b0;
		top = TMC16_MAX;
		next_cnt = s_q.cnt;
		set_ev = 4'h0;
		cnt_written = 1'b0;
		buf_update = 1'b0;
		s_d = s_q;
		s_d.presc = s_q.presc + 1'b1;

		// TOP selection
		case (top_select)
			TMC16_TOP_FIX8: top = TMC16_TOP_8BIT;
			TMC16_TOP_FIX9: top = TMC16_TOP_9BIT;
			TMC16_TOP_FIX10: top = TMC16_TOP_10BIT;
			TMC16_TOP_CMPA: top = s_q.cmpa;
			TMC16_TOP_CAP: top = s_q.cap;
			default: top = TMC16_MAX;
		endcase

		// Tick source; power-off freezes everything but bus and flags
		if (timer_power_off_bit) begin
			tick = 1'b0;
			s_d.presc = s_q.presc;
		end else if (clock_select == TMC16_CS_STOP) begin
			tick = 1'b0;
		end else if (clock_select == TMC16_CS_EXT_FALL || clock_select == TMC16_CS_EXT_RISE) begin
			tick = edges.count_event;
		end else begin
			tick = presc_tap(clock_select, s_q.presc);
		end

		// Counting; wraps at TOP, or at BOTTOM when counting down
		if (tick) begin
			if (!count_down && s_q.cnt == top) begin
				next_cnt = TMC16_BOTTOM;
				set_ev[TMC16_BIT_OVF] = 1'b1;
				buf_update = 1'b1;
			end else if (count_down && s_q.cnt == TMC16_BOTTOM) begin
				next_cnt = top;
				set_ev[TMC16_BIT_OVF] = 1'b1;
				buf_update = 1'b1;
			end else if (count_down) begin
				next_cnt = s_q.cnt - 1'b1;
			end else begin
				next_cnt = s_q.cnt + 1'b1;
			end
		end

		// Compare units run every cycle the counter ticks
		if (tick && s_q.cnt == s_q.cmpa) begin
			set_ev[TMC16_BIT_CMPA] = 1'b1;
		end
		if (tick && s_q.cnt == s_q.cmpb) begin
			set_ev[TMC16_BIT_CMPB] = 1'b1;
		end
		s_d.mat_a = set_ev[TMC16_BIT_CMPA];
		s_d.mat_b = set_ev[TMC16_BIT_CMPB];

		// Capture copies the counter and sets its flag together
		if (edges.capture_event && !timer_power_off_bit && top_select != TMC16_TOP_CAP) begin
			s_d.cap = s_q.cnt;
			set_ev[TMC16_BIT_CAP] = 1'b1;
		end

		// Buffered compare values move in at the count-sequence wrap,
		// or at once outside PWM so plain compares take effect quickly
		if (buf_update || !pwm_mode) begin
			s_d.cmpa = s_q.cmpa_buf;
			s_d.cmpb = s_q.cmpb_buf;
		end

		// Byte writes from the CPU
		if (bus_write) begin
			if (bus_addr[0]) begin
				s_d.latch = bus_wdata;
			end else if (bus_addr == TMC16_LOC_CNT_L) begin
				next_cnt = {s_q.latch, bus_wdata};
				cnt_written = 1'b1;
			end else if (bus_addr == TMC16_LOC_CMPA_L) begin
				s_d.cmpa_buf = {s_q.latch, bus_wdata};
			end else if (bus_addr == TMC16_LOC_CMPB_L) begin
				s_d.cmpb_buf = {s_q.latch, bus_wdata};
			end else if (bus_addr == TMC16_LOC_CAP_L && top_select == TMC16_TOP_CAP) begin
				s_d.cap = {s_q.latch, bus_wdata}; // Writable only as TOP
			end
		end
		s_d.cnt = next_cnt;
		s_d.tick = tick && !cnt_written;

		// Byte reads; the read byte shows on the next cycle
		s_d.rdata = 8'h00;
		if (bus_read) begin
			if (bus_addr == TMC16_LOC_CNT_L) begin
				s_d.rdata = s_q.cnt[7:0];
				s_d.latch = s_q.cnt[15:8];
			end else if (bus_addr == TMC16_LOC_CAP_L) begin
				s_d.rdata = s_q.cap[7:0];
				s_d.latch = s_q.cap[15:8];
			end else if (bus_addr == TMC16_LOC_CMPA_L) begin
				s_d.rdata = s_q.cmpa_buf[7:0];
			end else if (bus_addr == TMC16_LOC_CMPA_H) begin
				s_d.rdata = s_q.cmpa_buf[15:8];
			end else if (bus_addr == TMC16_LOC_CMPB_L) begin
				s_d.rdata = s_q.cmpb_buf[7:0];
			end else if (bus_addr == TMC16_LOC_CMPB_H) begin
				s_d.rdata = s_q.cmpb_buf[15:8];
			end else begin
				s_d.rdata = s_q.latch;
			end
		end

		// Flags: write one clears, but a new event wins over the clear
		if (flag_write) begin
			s_d.flags = (s_q.flags & ~flag_wdata) | set_ev;
		end else begin
			s_d.flags = s_q.flags | set_ev;
		end
		if (mask_write) begin
			s_d.mask = mask_wdata;
		end
		s_d.irq = |(s_d.flags & s_d.mask);

		// Limit indicators on the next counter value
		s_d.bot = (next_cnt == TMC16_BOTTOM);
		s_d.mx = (next_cnt == TMC16_MAX);
		s_d.tp = (next_cnt == top);
		s_d.pwm_a = !(pwm_mode && top_select == TMC16_TOP_CMPA);
	end

	// Register the state; everything zero after reset except bot and pwm_a, which reset to one
	always_ff @(posedge clock) begin
		if (rst) begin
			s_q <= '0;
			s_q.bot <= 1'b1;
			s_q.pwm_a <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------
	assign bus_rdata = s_q.rdata;
	assign interrupt_flag_register = s_q.flags;
	assign interrupt_mask_register = s_q.mask;
	assign interrupt_request = s_q.irq;
	assign counter_value = s_q.cnt;
	assign compare_match_a = s_q.mat_a;
	assign compare_match_b = s_q.mat_b;
	assign pwm_output_a_allowed = s_q.pwm_a;
	assign at_bottom = s_q.bot;
	assign at_max = s_q.mx;
	assign at_top = s_q.tp;
	assign timer_tick = s_q.tick;

endmodule

// ===== logic/tmc16_pkg.sv
// Package of constants and types for the 16-bit timer core with byte access
package tmc16_pkg;

	// ----------------------------------------
	// Byte locations on the CPU data bus
	// ----------------------------------------
	localparam logic [2:0] TMC16_LOC_CNT_L = 3'h0; // Counter low byte
	localparam logic [2:0] TMC16_LOC_CNT_H = 3'h1; // Counter high byte
	localparam logic [2:0] TMC16_LOC_CMPA_L = 3'h2; // Compare A low byte
	localparam logic [2:0] TMC16_LOC_CMPA_H = 3'h3; // Compare A high byte
	localparam logic [2:0] TMC16_LOC_CMPB_L = 3'h4; // Compare B low byte
	localparam logic [2:0] TMC16_LOC_CMPB_H = 3'h5; // Compare B high byte
	localparam logic [2:0] TMC16_LOC_CAP_L = 3'h6; // Capture low byte
	localparam logic [2:0] TMC16_LOC_CAP_H = 3'h7; // Capture high byte

	// ----------------------------------------
	// Limits and reset values
	// ----------------------------------------
	localparam logic [15:0] TMC16_BOTTOM = 16'h0000;
	localparam logic [15:0] TMC16_MAX = 16'hFFFF;
	localparam logic [15:0] TMC16_TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TMC16_TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TMC16_TOP_10BIT = 16'h03FF;
	localparam logic [15:0] TMC16_RESET_WORD = 16'h0000;
	localparam logic [7:0] TMC16_RESET_BYTE = 8'h00;
	localparam logic [3:0] TMC16_RESET_FLAGS = 4'h0;

	// ----------------------------------------
	// Field positions in flag and mask vectors
	// ----------------------------------------
	localparam int TMC16_BIT_OVF = 0; // Overflow
	localparam int TMC16_BIT_CMPA = 1; // Compare A match
	localparam int TMC16_BIT_CMPB = 2; // Compare B match
	localparam int TMC16_BIT_CAP = 3; // Capture

	// ----------------------------------------
	// Prescaler and filter counts
	// ----------------------------------------
	localparam int TMC16_PRESC_WIDTH = 10; // Divides by up to 1024
	localparam int TMC16_FILTER_LEN = 4; // Equal samples needed by filter

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	// Clock select codes, as 3-bit field
	typedef enum logic [2:0] {
		TMC16_CS_STOP, TMC16_CS_DIV1, TMC16_CS_DIV8, TMC16_CS_DIV64,
		TMC16_CS_DIV256, TMC16_CS_DIV1024, TMC16_CS_EXT_FALL, TMC16_CS_EXT_RISE
	} tmc16_clksel_type;

	// TOP source selection
	typedef enum logic [2:0] {
		TMC16_TOP_MAX, TMC16_TOP_FIX8, TMC16_TOP_FIX9, TMC16_TOP_FIX10,
		TMC16_TOP_CMPA, TMC16_TOP_CAP
	} tmc16_topsel_type;

endpackage

// ===== logic/tmc16_edge_if.sv
// Interface carrying the filtered capture and unfiltered count edge events between edge detector and core
interface tmc16_edge_if;
	logic capture_event; // One-cycle qualified capture edge
	logic count_event; // One-cycle qualified external count edge
	modport source (output capture_event, output count_event);
	modport sink (input capture_event, input count_event);
endinterface

// ===== logic/tmc16_edge_detect.sv
// Noise filter for the capture pin and edge detection for the capture and external count pins
module tmc16_edge_detect
	import tmc16_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic capture_input_pin,
	input wire logic external_count_pin,
	input wire logic filter_enable,
	input wire logic capture_rising,
	input wire logic count_rising,
	tmc16_edge_if.source edges
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [TMC16_FILTER_LEN-1:0] cap_hist; // Recent capture pin samples
		logic cap_level; // Accepted capture level
		logic cnt_prev; // Last count pin sample
		logic cap_evt; // Capture edge pulse
		logic cnt_evt; // Count edge pulse
	} tmc16_edge_state_type;

	tmc16_edge_state_type state_q, state_d;

	// Filter needs all samples equal before level changes; costs extra latency
	always_comb begin
		logic new_level;
		new_level = state_q.cap_level;
		state_d = state_q;
		state_d.cap_hist = {state_q.cap_hist[TMC16_FILTER_LEN-2:0], capture_input_pin};
		if (!filter_enable) begin
			new_level = capture_input_pin; // Filter bypassed
		end else if (&state_d.cap_hist) begin
			new_level = 1'b1;
		end else if (~|state_d.cap_hist) begin
			new_level = 1'b0;
		end
		state_d.cap_level = new_level;
		// Qualifying edge only in the chosen direction
		state_d.cap_evt = (new_level != state_q.cap_level) && (new_level == capture_rising);
		state_d.cnt_prev = external_count_pin;
		state_d.cnt_evt = (external_count_pin != state_q.cnt_prev) && (external_count_pin == count_rising);
	end

	// Register the state; synchronous reset
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign edges.capture_event = state_q.cap_evt;
	assign edges.count_event = state_q.cnt_evt;

endmodule

// ===== verif/tmc16_cpu_model.sv
// CPU-side bus model issuing byte-wide 16-bit accesses
module tmc16_cpu_model(
	input wire logic clock,
	input wire logic [7:0] bus_rdata,
	output logic [2:0] bus_addr,
	output logic bus_write,
	output logic bus_read,
	output logic [7:0] bus_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial begin
		bus_addr = 3'h0;
		bus_write = 1'b0;
		bus_read = 1'b0;
		bus_wdata = 8'h00;
	end
	// One byte cycle from the falling edge; idle data toggles so stale bytes never look valid
	task automatic step(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
		@(negedge clock);
		bus_write = w;
		bus_read = r;
		bus_addr = a;
		bus_wdata = w ? d : ~bus_wdata;
	endtask
	// Pairs go back to back, so nothing else can touch the shared latch in between
	task automatic wr16(input logic [2:0] a, input logic [15:0] val);
		step(1'b1, 1'b0, a | 3'h1, val[15:8]);
		step(1'b1, 1'b0, a & 3'h6, val[7:0]);
		step(1'b0, 1'b0, a, 8'h00);
	endtask
	// Low byte first so the latch holds the matching high byte
	task automatic rd16(input logic [2:0] a, output logic [15:0] val);
		step(1'b0, 1'b1, a & 3'h6, 8'h00);
		step(1'b0, 1'b1, a | 3'h1, 8'h00);
		val[7:0] = bus_rdata;
		step(1'b0, 1'b0, a, 8'h00);
		val[15:8] = bus_rdata;
	endtask
endmodule

// ===== verif/tmc16_core_checker.sv
// Concurrent checks on the timer core ports
module tmc16_core_checker(
	input wire logic clock,
	input wire logic rst,
	input wire logic timer_power_off_bit,
	input wire logic [2:0] clock_select,
	input wire logic [2:0] bus_addr,
	input wire logic bus_write,
	input wire logic bus_read,
	input wire logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata,
	input wire logic [3:0] interrupt_flag_register,
	input wire logic [3:0] interrupt_mask_register,
	input wire logic interrupt_request,
	input wire logic [15:0] counter_value,
	input wire logic compare_match_a,
	input wire logic at_bottom,
	input wire logic at_max,
	input wire logic timer_tick
);
	// ----
	// Byte access steps
	// ----
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence s_wr_hi;
		bus_write && bus_addr == 3'h1;
	endsequence
	sequence s_wr_lo;
		bus_write && bus_addr == 3'h0;
	endsequence
	sequence s_rd_lo;
		bus_read && bus_addr == 3'h0;
	endsequence
	sequence s_rd_hi;
		bus_read && bus_addr == 3'h1;
	endsequence
	// ----
	// Checks
	// ----
	a_power_hold: assert property (timer_power_off_bit |=> !timer_tick) else $error("tick when off");
	a_stop_hold: assert property (clock_select == 3'h0 && $past(clock_select) == 3'h0 && !bus_write
		|=> $stable(counter_value)) else $error("counter moved when stopped");
	a_limit_flags: assert property (at_bottom == (counter_value == 16'h0000)
		&& at_max == (counter_value == 16'hFFFF)) else $error("limit flag wrong");
	a_match_flag: assert property (compare_match_a |-> interrupt_flag_register[1]) else $error("no flag");
	a_irq_level: assert property (interrupt_request == |(interrupt_flag_register
		& interrupt_mask_register)) else $error("request wrong");
	a_low_commit: assert property (s_wr_hi ##1 s_wr_lo |=> counter_value
		== {$past(bus_wdata, 2), $past(bus_wdata)}) else $error("word write wrong");
	a_low_read: assert property (s_rd_lo |=> bus_rdata == $past(counter_value[7:0])) else $error("low read");
	a_latch_read: assert property (s_rd_lo ##1 s_rd_hi |=> bus_rdata
		== $past(counter_value[15:8], 2)) else $error("latch read wrong");
	a_cmp_bypass: assert property (s_rd_lo ##1 (bus_read && bus_addr == 3'h2) ##1 s_rd_hi
		|=> bus_rdata == $past(counter_value[15:8], 3)) else $error("latch disturbed");
	a_write_prio: assert property (s_wr_lo |=> !timer_tick) else $error("count beat write");
endmodule
bind tmc16_core tmc16_core_checker u_chk(.clock, .rst, .timer_power_off_bit, .clock_select, .bus_addr,
	.bus_write, .bus_read, .bus_wdata, .bus_rdata, .interrupt_flag_register, .interrupt_mask_register,
	.interrupt_request, .counter_value, .compare_match_a, .at_bottom, .at_max, .timer_tick);

// ===== verif/tmc16_core_tb_top.sv
// Self-checking bench for the 16-bit timer core
module tmc16_core_tb_top
	import tmc16_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [15:0] val; logic bot; logic mx;} tmc16_row_type;
	logic clock = 1'b0, rst = 1'b1, timer_power_off_bit = 1'b0, pwm_mode = 1'b0, count_down = 1'b0;
	logic filter_enable = 1'b0, capture_rising = 1'b1, flag_write = 1'b0, mask_write = 1'b0;
	logic capture_input_pin = 1'b0, external_count_pin = 1'b0, bus_write, bus_read;
	logic [2:0] clock_select = 3'h0, top_select = 3'h0, bus_addr;
	logic [3:0] flag_wdata = 4'h0, mask_wdata = 4'h0, interrupt_flag_register, interrupt_mask_register;
	logic [7:0] bus_wdata, bus_rdata;
	logic [15:0] v, c;
	logic [15:0] counter_value;
	logic interrupt_request, compare_match_a, compare_match_b, pwm_output_a_allowed, at_bottom, at_max;
	logic at_top, timer_tick;
	int n_fail = 0;
	int checks_done = 0;
	// Boundary words: bottom, max, a fixed top and a split pattern
	tmc16_row_type rows [4] = '{'{16'h0000, 1'b1, 1'b0}, '{16'hFFFF, 1'b0, 1'b1},
		'{16'h01FF, 1'b0, 1'b0}, '{16'h8001, 1'b0, 1'b0}};
	logic [15:0] tops [3] = '{TMC16_TOP_8BIT, TMC16_TOP_9BIT, TMC16_TOP_10BIT};
	always #10 clock = ~clock;
	tmc16_cpu_model u_cpu(.clock, .bus_rdata, .bus_addr, .bus_write, .bus_read, .bus_wdata);
	tmc16_core u_dut(.clock, .rst, .timer_power_off_bit, .clock_select, .top_select, .pwm_mode, .count_down,
		.filter_enable, .capture_rising, .bus_addr, .bus_write, .bus_read, .bus_wdata, .flag_write,
		.flag_wdata, .mask_write, .mask_wdata, .capture_input_pin, .external_count_pin, .bus_rdata,
		.interrupt_flag_register, .interrupt_mask_register, .interrupt_request, .counter_value,
		.compare_match_a, .compare_match_b, .pwm_output_a_allowed, .at_bottom, .at_max, .at_top, .timer_tick);
	// ----
	// Compare and closing tasks
	// ----
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk1(input string nm, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %b seen %b", nm, exp, got);
		end
	endtask
	// Bounded wait for one flag; running out ends the run
	task automatic wait_flag(input int i, input int lim);
		for (int k = 0; k < lim && interrupt_flag_register[i] !== 1'b1; k++)
			@(negedge clock);
		chk1("flag set", 1'b1, interrupt_flag_register[i]);
		if (n_fail != 0)
			report_and_stop();
	endtask
	task automatic clr(input logic [3:0] m);
		@(negedge clock);
		flag_write = 1'b1;
		flag_wdata = m;
		@(negedge clock);
		flag_write = 1'b0;
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		repeat (2) @(negedge clock);
		rst = 1'b0;
		chk16("counter", 16'h0000, counter_value);
		chk16("flags", 16'h0000, {8'h00, interrupt_flag_register, interrupt_mask_register});
		for (int a = 2; a < 8; a += 2) begin
			u_cpu.rd16(3'(a), v);
			chk16("reset word", 16'h0000, v);
		end
		foreach (rows[i]) begin
			u_cpu.wr16(TMC16_LOC_CNT_L, rows[i].val);
			chk16("counter", rows[i].val, counter_value);
			chk1("bottom", rows[i].bot, at_bottom);
			chk1("max", rows[i].mx, at_max);
			u_cpu.wr16(TMC16_LOC_CMPA_L, ~rows[i].val);
			chk16("counter kept", rows[i].val, counter_value);
			u_cpu.rd16(TMC16_LOC_CNT_L, v);
			chk16("counter read", rows[i].val, v);
			u_cpu.rd16(TMC16_LOC_CMPA_L, v);
			chk16("compare read", ~rows[i].val, v);
		end
		// Compare read between the two counter bytes must leave the latch alone
		u_cpu.step(1'b0, 1'b1, TMC16_LOC_CNT_L, 8'h00);
		u_cpu.step(1'b0, 1'b1, TMC16_LOC_CMPA_L, 8'h00);
		u_cpu.step(1'b0, 1'b1, TMC16_LOC_CNT_H, 8'h00);
		u_cpu.step(1'b0, 1'b0, TMC16_LOC_CNT_L, 8'h00);
		chk16("latch", 16'h0080, {8'h00, bus_rdata});
		u_cpu.wr16(TMC16_LOC_CMPA_L, 16'h0005);
		mask_write = 1'b1;
		mask_wdata = 4'h2;
		@(negedge clock);
		mask_write = 1'b0;
		clock_select = 3'h1;
		u_cpu.wr16(TMC16_LOC_CNT_L, 16'h0000);
		chk16("write wins", 16'h0000, counter_value);
		wait_flag(TMC16_BIT_CMPA, 20);
		chk1("request", 1'b1, interrupt_request);
		clock_select = 3'h0;
		clr(4'h2);
		chk1("request off", 1'b0, interrupt_request | interrupt_flag_register[1]);
		c = counter_value;
		timer_power_off_bit = 1'b1;
		clock_select = 3'h1;
		repeat (10) @(negedge clock);
		chk16("frozen", c, counter_value);
		timer_power_off_bit = 1'b0;
		repeat (5) @(negedge clock);
		chk1("runs", 1'b1, counter_value != c);
		foreach (tops[i]) begin
			clock_select = 3'h0;
			top_select = 3'(i + 1);
			clr(4'h1);
			u_cpu.wr16(TMC16_LOC_CNT_L, tops[i] - 16'h0002);
			clock_select = 3'h1;
			wait_flag(TMC16_BIT_OVF, 8);
			chk1("wrapped", 1'b1, counter_value < 16'h0004);
		end
		top_select = 3'h0;
		filter_enable = 1'b1;
		clr(4'h8);
		capture_input_pin = 1'b1;
		@(negedge clock);
		capture_input_pin = 1'b0;
		repeat (12) @(negedge clock);
		chk1("spike", 1'b0, interrupt_flag_register[3]);
		capture_input_pin = 1'b1;
		c = counter_value;
		wait_flag(TMC16_BIT_CAP, 20);
		clock_select = 3'h0;
		u_cpu.rd16(TMC16_LOC_CAP_L, v);
		chk1("stamp", 1'b1, (v - c) inside {[16'h0001:16'h0010]});
		clock_select = 3'h7;
		c = counter_value;
		for (int k = 0; k < 6; k++) begin
			if (k == 3)
				clock_select = 3'h6;
			external_count_pin = 1'b1;
			repeat (4) @(negedge clock);
			external_count_pin = 1'b0;
			repeat (4) @(negedge clock);
		end
		repeat (4) @(negedge clock);
		chk16("external", c + 16'h0006, counter_value);
		// Count down to a TOP held in compare A: the new value waits for the wrap
		clock_select = 3'h0;
		top_select = 3'h4;
		pwm_mode = 1'b1;
		count_down = 1'b1;
		u_cpu.wr16(TMC16_LOC_CMPA_L, 16'h0003);
		chk1("pwm a", 1'b0, pwm_output_a_allowed);
		u_cpu.wr16(TMC16_LOC_CNT_L, 16'h0000);
		clock_select = 3'h1;
		@(negedge clock);
		chk16("old top", 16'h0005, counter_value);
		repeat (6) @(negedge clock);
		chk16("new top", 16'h0003, counter_value);
		chk1("top", 1'b1, at_top);
		// Compare B pulse while counting up, buffer passed straight through
		clock_select = 3'h0;
		top_select = 3'h0;
		pwm_mode = 1'b0;
		count_down = 1'b0;
		u_cpu.wr16(TMC16_LOC_CMPB_L, 16'h0010);
		u_cpu.wr16(TMC16_LOC_CNT_L, 16'h000E);
		clr(4'h4);
		clock_select = 3'h1;
		repeat (3) @(negedge clock);
		chk1("match b", 1'b1, compare_match_b & interrupt_flag_register[2]);
		chk1("tick", 1'b1, timer_tick);
		@(negedge clock);
		chk1("match b pulse", 1'b0, compare_match_b);
		// Reset in mid-run; a high capture pin must not look like a falling edge
		clock_select = 3'h0;
		rst = 1'b1;
		filter_enable = 1'b0;
		capture_rising = 1'b0;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		chk16("counter", 16'h0000, counter_value);
		chk16("flags", 16'h0000, {8'h00, interrupt_flag_register, interrupt_mask_register});
		chk1("reset limits", 1'b1, at_bottom & pwm_output_a_allowed & !at_top);
		u_cpu.rd16(TMC16_LOC_CMPB_L, v);
		chk16("reset compare", 16'h0000, v);
		clock_select = 3'h1;
		capture_input_pin = 1'b0;
		wait_flag(TMC16_BIT_CAP, 8);
		// Any 16 cycles hold exactly two divide-by-8 taps, whatever the prescaler phase
		c = counter_value;
		clock_select = 3'h2;
		repeat (16) @(negedge clock);
		chk16("divide by 8", c + 16'h0002, counter_value);
		report_and_stop();
	end
endmodule
